/* File: bench/dct_top_bench.sv */
// Self-checking bench for the dual counter/timer control.
// Drives dct_top through its byte access port; checker bound below.
`timescale 1ns/1ps
module dct_top_bench;
   reg        clk;
   reg        rst_n;
   reg  [7:0] addr;
   reg  [7:0] wdata;
   reg        wr_en;
   reg        rd_en;
   reg        pa;
   reg        pb;
   reg        dm;
   wire [7:0] rdata;
   wire       rd_valid;
   wire       pin_a;
   wire       pin_b;
   wire       byte_irq;
   wire       word_irq;
   wire       cap_irq;
   reg  [7:0] rv;
   integer    n_fail;
   integer    compares;
   integer    t;
   integer    n;
   integer    k;

   dct_top i_dut (
      .clock_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en),
      .wdata_i(wdata), .rdata_o(rdata), .rd_valid_o(rd_valid), .port_a_data_i(pa),
      .port_b_data_i(pb), .demod_in_i(dm), .shared_pin_a_o(pin_a), .shared_pin_b_o(pin_b),
      .byte_irq_o(byte_irq), .word_irq_o(word_irq), .capture_irq_o(cap_irq)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task end_sim;
      begin
         $display("%0d compares, %0d wrong", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [7:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr_en <= 1'b1;
         @(posedge clk);
         wr_en <= 1'b0;
         @(posedge clk);
      end
   endtask

   task rd(input [7:0] a);
      integer i;
      begin
         rv = 8'hxx;
         addr <= a;
         rd_en <= 1'b1;
         @(posedge clk);
         rd_en <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            #1;
            if (rd_valid === 1'b1)
               rv = rdata;
            @(posedge clk);
         end
      end
   endtask

   function sig(input integer w);
      case (w)
         0: sig = byte_irq;
         1: sig = word_irq;
         2: sig = cap_irq;
         3: sig = pin_a;
         default: sig = pin_b;
      endcase
   endfunction

   // Counts edges until the watched output changes, at most 300
   task wait_chg(input integer w, output integer c);
      reg v0;
      begin
         #1;
         v0 = sig(w);
         c = 0;
         while (sig(w) === v0 && c < 300) begin
            @(posedge clk);
            #1;
            c = c + 1;
         end
         @(posedge clk);
      end
   endtask

   initial begin
      #(25 * 20000);
      n_fail = n_fail + 1;
      end_sim;
   end

   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      pa = 1'b0;
      pb = 1'b0;
      dm = 1'b0;
      n_fail = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      pa <= 1'b1;
      pb <= 1'b1;
      rd(8'hfd);
      chk(rv, 8'h00);
      wr(8'hfd, 8'h0d);
      rd(8'h03);
      chk(rv, 8'h00);
      rd(8'h00);
      chk(rv, 8'h00);
      chk({3'b000, byte_irq, word_irq, cap_irq, pin_a, pin_b}, 8'h03);
      pa <= 1'b0;
      pb <= 1'b0;
      $display("test reset done");
      wr(8'hfd, 8'h00);
      wr(8'h00, 8'h5a);
      wr(8'hfd, 8'h20);
      wr(8'he3, 8'ha5);
      rd(8'h23);
      chk(rv, 8'ha5);
      wr(8'hfd, 8'h0f);
      rd(8'h00);
      chk(rv, 8'h00);
      wr(8'hfd, 8'h00);
      rd(8'h00);
      chk(rv, 8'h5a);
      wr(8'hfd, 8'h0d);
      rd(8'h05);
      chk(rv, 8'h00);
      $display("test banks done");
      wr(8'h03, 8'hc0);
      rd(8'h03);
      chk(rv & 8'hc0, 8'hc0);
      wr(8'h03, 8'h00);
      rd(8'h03);
      chk(rv, 8'h00);
      $display("test run bits done");
      wr(8'h0a, 8'h01);
      wr(8'h08, 8'h01);
      wr(8'h09, 8'h00);
      for (t = 0; t < 2; t = t + 1) begin
         for (n = 0; n < 4; n = n + 1) begin
            wr(8'h03, 8'h00);
            wr({6'h00, t[0], 1'b0}, 8'h81 | {3'b000, n[1:0], 3'b000});
            wait_chg(3 + t, k);
            wait_chg(3 + t, k);
            chk(k[7:0] + 8'h01, 8'h02 << (n + 1));
         end
      end
      $display("test clock select done");
      for (t = 0; t < 2; t = t + 1) begin
         wr(8'h03, 8'h00);
         rd({6'h00, t[0], 1'b0});
         chk(rv & 8'h20, 8'h20);
         wr({6'h00, t[0], 1'b0}, 8'h02);
         chk({7'h00, sig(t)}, 8'h01);
         rd({6'h00, t[0], 1'b0});
         chk(rv & 8'h20, 8'h20);
         wr({6'h00, t[0], 1'b0}, 8'h22);
         rd({6'h00, t[0], 1'b0});
         chk(rv & 8'h20, 8'h00);
         chk({7'h00, sig(t)}, 8'h00);
      end
      $display("test flags done");
      wr(8'h0a, 8'h02);
      wr(8'h00, 8'h20);
      wr(8'h00, 8'hc0);
      rv = 8'h40;
      for (k = 0; k < 10 && rv[6] !== 1'b0; k = k + 1)
         rd(8'h03);
      chk(rv & 8'h40, 8'h00);
      rd(8'h00);
      chk(rv & 8'h20, 8'h20);
      $display("test single pass done");
      wr(8'h08, 8'hff);
      wr(8'h09, 8'hff);
      wr(8'h01, 8'h20);
      wr(8'h02, 8'h84);
      wr(8'h01, 8'h80);
      dm <= ~dm;
      wait_chg(2, k);
      chk({7'h00, cap_irq}, 8'h01);
      wr(8'h01, 8'ha0);
      chk({7'h00, cap_irq}, 8'h00);
      dm <= ~dm;
      wait_chg(2, k);
      chk({7'h00, cap_irq}, 8'h01);
      wr(8'h01, 8'hc0);
      wr(8'h03, 8'h00);
      wr(8'h03, 8'h80);
      wr(8'h01, 8'he0);
      dm <= ~dm;
      wait_chg(2, k);
      chk({7'h00, cap_irq}, 8'h01);
      wr(8'h01, 8'he0);
      dm <= ~dm;
      wait_chg(2, k);
      chk({7'h00, cap_irq}, 8'h00);
      $display("test demodulation done");
      wr(8'h03, 8'h00);
      wr(8'h03, 8'h20);
      wr(8'h00, 8'h80);
      rd(8'h03);
      chk(rv & 8'he0, 8'he0);
      wr(8'h03, 8'h00);
      wr(8'h00, 8'h80);
      rd(8'h03);
      chk(rv & 8'he0, 8'h40);
      $display("test sync done");
      end_sim;
   end
endmodule

bind dct_top dct_top_checker i_chk (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
   .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
   .port_a_data_i(port_a_data_i), .port_b_data_i(port_b_data_i),
   .shared_pin_a_o(shared_pin_a_o), .shared_pin_b_o(shared_pin_b_o),
   .byte_irq_o(byte_irq_o), .word_irq_o(word_irq_o), .capture_irq_o(capture_irq_o)
);

/* File: bench/dct_top_checker.sv */
// Concurrent checks on the dual counter/timer control ports.
// Bound to dct_top; keeps its own copy of the register pointer.
`timescale 1ns/1ps
module dct_top_checker (
   // Clock and reset
   input wire       clock_i,
   input wire       rst_n_i,
   // Register access port
   input wire [7:0] addr_i,
   input wire       wr_en_i,
   input wire       rd_en_i,
   input wire [7:0] wdata_i,
   input wire [7:0] rdata_o,
   input wire       rd_valid_o,
   // Pins and requests
   input wire       port_a_data_i,
   input wire       port_b_data_i,
   input wire       shared_pin_a_o,
   input wire       shared_pin_b_o,
   input wire       byte_irq_o,
   input wire       word_irq_o,
   input wire       capture_irq_o
);
   reg  [7:0] ptr;
   wire       dh   = addr_i[7:4] == 4'h0 && ptr[3:0] == 4'hd;
   wire       b_wr = wr_en_i && dh && addr_i[3:0] == 4'h0;
   wire       w_wr = wr_en_i && dh && addr_i[3:0] == 4'h2;
   wire       c_wr = wr_en_i && dh && addr_i[3:0] == 4'h3;
   wire       c_rd = rd_en_i && dh && addr_i[3:0] == 4'h3;
   wire       hole = addr_i[3:0] > 4'ha || (addr_i[3:0] > 4'h3 && addr_i[3:0] < 4'h8);
   wire       z_rd = rd_en_i && addr_i[7:4] == 4'h0 && ptr[3:0] != 4'h0 && (!dh || hole);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         ptr <= 8'h00;
      else if (wr_en_i && addr_i == 8'hfd)
         ptr <= wdata_i;
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   read_answer_a: assert property (rd_en_i |-> ##2 rd_valid_o)
      else $error("read answer not two cycles after request");
   answer_cause_a: assert property (rd_valid_o |-> $past(rd_en_i, 2))
      else $error("read answer without request");
   byte_mask_a: assert property (b_wr && !wdata_i[1] |=> !byte_irq_o)
      else $error("byte request while masked");
   word_mask_a: assert property (w_wr && !wdata_i[1] |=> !word_irq_o)
      else $error("word request while masked");
   cap_mask_a: assert property (w_wr && !wdata_i[2] |=> !capture_irq_o)
      else $error("capture request while masked");
   pin_a_port_a: assert property (b_wr && !wdata_i[0] |=> shared_pin_a_o == port_a_data_i)
      else $error("pin a not showing port data");
   pin_b_port_a: assert property (w_wr && !wdata_i[0] |=> shared_pin_b_o == port_b_data_i)
      else $error("pin b not showing port data");
   stop_read_a: assert property (c_wr && wdata_i[7:6] == 2'b00 ##2 c_rd |-> ##2 rdata_o[7:6] == 2'b00)
      else $error("counter still running after stop");
   start_run_a: assert property (b_wr && wdata_i[7] && !wdata_i[6] ##2 c_rd |-> ##2 rdata_o[6])
      else $error("byte counter not running after enable");
   hole_zero_a: assert property (z_rd |-> ##2 rdata_o == 8'h00)
      else $error("absent bank register reads nonzero");
   ptr_back_a: assert property (rd_en_i && addr_i == 8'hfd |-> ##2 rdata_o == $past(ptr, 2))
      else $error("pointer read back wrong");
endmodule

/* File: hdl/dct_counter.v */
// Down counter with load, reload, single-pass stop and terminal count pulse.
// Assumes tick_i is a one-cycle enable from a prescaler.
`timescale 1ns/1ps
module dct_counter #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         clock_i,
   input  wire         rst_n_i,
   // Control
   input  wire         start_i,
   input  wire         stop_i,
   input  wire         tick_i,
   input  wire         reload_i,
   input  wire         single_i,
   input  wire [W-1:0] init_i,
   // Status
   output reg  [W-1:0] count_o,
   output reg          running_o,
   output reg          tc_o
);
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o   <= {W{1'b0}};
         running_o <= 1'b0;
         tc_o      <= 1'b0;
      end else begin
         tc_o <= 1'b0;
         if (start_i) begin
            count_o   <= init_i;
            running_o <= 1'b1;
         end else if (stop_i) begin
            running_o <= 1'b0;
         end else if (running_o && reload_i) begin
            count_o <= init_i;
         end else if (running_o && tick_i) begin
            if (count_o == {W{1'b0}}) begin
               tc_o <= 1'b1;
               if (single_i) begin
                  running_o <= 1'b0;
               end else begin
                  count_o <= init_i;
               end
            end else begin
               count_o <= count_o - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

/* File: hdl/dct_map.vh */
// Register map, field positions and reset values of the dual counter/timer control.
// Included by the top-level design file; definitions only.
`ifndef DCT_MAP_VH
`define DCT_MAP_VH

// Register pointer and addressing
`define DCT_RP_ADDR        8'hfd
`define DCT_WREG_GROUP     4'he
`define DCT_BANK_NORMAL    4'h0
`define DCT_BANK_D         4'hd
`define DCT_BANK_F         4'hf
`define DCT_SWAP_GROUP     4'h0

// Offsets inside bank D
`define DCT_OFF_BYTE_CTL   4'h0
`define DCT_OFF_DEMOD_CTL  4'h1
`define DCT_OFF_WORD_CTL   4'h2
`define DCT_OFF_COMB_CTL   4'h3
`define DCT_OFF_CAP_LOW    4'h8
`define DCT_OFF_CAP_HIGH   4'h9
`define DCT_OFF_BYTE_INIT  4'ha

// Field positions of the byte and word timer control registers
`define DCT_B_ENABLE       7
`define DCT_B_SINGLE       6
`define DCT_B_TIMEOUT      5
`define DCT_B_CLK_HI       4
`define DCT_B_CLK_LO       3
`define DCT_B_CAP_MASK     2
`define DCT_B_INT_MASK     1
`define DCT_B_PIN_SEL      0

// Field positions of the demodulation control register
`define DCT_B_DEMOD_EN     7
`define DCT_B_EDGE_FIRST   6
`define DCT_B_CAP_FLAG     5

// Field positions of the combined control register
`define DCT_B_WORD_RUN     7
`define DCT_B_BYTE_RUN     6
`define DCT_B_SYNC         5

// Reset values
`define DCT_RST_BYTE       8'h00
`define DCT_RST_WORD       16'h0000
`define DCT_RST_RP         8'h00
`define DCT_RST_CLKSEL     2'h0

// Prescaler width; clock select n divides the system clock by 2^(n+1)
`define DCT_PRE_W          4

`endif

/* File: hdl/dct_regfile.v */
// Byte-wide general register file with registered read data.
// Assumes one write or read per cycle from the owning block.
`timescale 1ns/1ps
module dct_regfile #(
   parameter AW = 8,
   parameter DW = 8
) (
   // Clock and reset
   input  wire          clock_i,
   input  wire          rst_n_i,
   // Access port
   input  wire [AW-1:0] addr_i,
   input  wire          wr_en_i,
   input  wire [DW-1:0] wdata_i,
   input  wire          rd_en_i,
   output reg  [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clock_i) begin
      if (wr_en_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= {DW{1'b0}};
      end else if (rd_en_i) begin
         rdata_o <= mem[addr_i];
      end
   end
endmodule

/* File: hdl/dct_top.v */
// Control of an 8-bit and a 16-bit counter/timer behind a banked register file.
// Assumes a CPU-style byte access port synchronous to clock_i.
//
// How it works
// - Writing 1 to the byte timer enable bit starts the byte timer.
// - Repeat bit 0 reloads at terminal count; 1 stops there.
// - Byte time-out flag sets at terminal count; clears only by writing 1.
// - First count tick after enabling may be short and arrive anytime.
// - Byte control bit 1 gates the byte time-out interrupt.
// - Byte control bit 0 steers byte timer output onto shared pin A.
// - Clock-select field picks the byte counter input clock rate.
// - Demodulation: edge bit 0 acts on every edge, 1 on first only.
// - Word time-out flag sets at terminal count; clears only by writing 1.
// - Clock-select field picks the word counter input clock rate.
// - Capture interrupt enable requests an interrupt on every capture.
// - Word interrupt enable requests an interrupt at word terminal count.
// - Pin-select bit steers word timer output onto shared pin B.
// - Combined bit 7 shows word run state; writes start or stop it.
// - Combined bit 6 shows byte run state; writes start or stop it.
// - Combined bit 5 enables synchronised start of both counters; default 0.
// - Pointer upper nibble picks the 16-byte working register group.
// - Nonzero pointer low nibble swaps the lowest 16 registers for a bank.
`timescale 1ns/1ps
`include "dct_map.vh"
module dct_top #(
   parameter AW = 8,
   parameter DW = 8
) (
   // Clock and reset
   input  wire          clock_i,
   input  wire          rst_n_i,
   // Register access port
   input  wire [AW-1:0] addr_i,
   input  wire          wr_en_i,
   input  wire          rd_en_i,
   input  wire [DW-1:0] wdata_i,
   output reg  [DW-1:0] rdata_o,
   output reg           rd_valid_o,
   // Port data and demodulation input
   input  wire          port_a_data_i,
   input  wire          port_b_data_i,
   input  wire          demod_in_i,
   // Shared pins
   output wire          shared_pin_a_o,
   output wire          shared_pin_b_o,
   // Interrupt requests
   output wire          byte_irq_o,
   output wire          word_irq_o,
   output wire          capture_irq_o
);
   // Register pointer and decode
   reg  [7:0]    register_pointer;
   wire [AW-1:0] eff_addr;
   wire          swap;
   wire          hit_d;
   wire          hit_rp;
   wire          mem_wr;
   wire          mem_rd;

   // Byte timer control fields
   reg        byte_single;
   reg [1:0]  byte_clksel;
   reg        byte_int_mask;
   reg        byte_timer_pin_select;
   reg        byte_timeout;
   reg [7:0]  byte_init;
   reg        byte_out;

   // Word timer control fields
   reg        word_single;
   reg [1:0]  word_clksel;
   reg        word_cap_mask;
   reg        word_int_mask;
   reg        word_timer_pin_select;
   reg        word_timeout;
   reg [15:0] word_init;
   reg        word_out;

   // Demodulation and sync
   reg        demod_en;
   reg        edge_first;
   reg        cap_flag;
   reg        sync_mode;
   reg [15:0] capture_word;
   reg        demod_q;
   reg        armed;

   // Prescaler and counter links
   reg  [`DCT_PRE_W-1:0] prescale;
   wire       byte_tick;
   wire       word_tick;
   wire [7:0] byte_count;
   wire [15:0] word_count;
   wire       byte_running;
   wire       word_running;
   wire       byte_tc;
   wire       word_tc;
   wire       raw_start_b;
   wire       raw_start_w;
   wire       start_b;
   wire       start_w;
   wire       stop_b;
   wire       stop_w;
   wire       demod_act;

   // Read path
   wire [DW-1:0] mem_q;
   reg  [DW-1:0] periph_q;
   reg           use_mem;
   reg           rd_stage;

   // True for a write to bank D register at offset off
   function wr_reg;
      input [3:0] off;
      begin
         wr_reg = wr_en_i && hit_d && (eff_addr[3:0] == off);
      end
   endfunction

   // One-cycle tick when the prescaler wraps at 2^(sel+1)
   function tick_of;
      input [1:0]            sel;
      input [`DCT_PRE_W-1:0] pre;
      reg   [`DCT_PRE_W-1:0] mask;
      begin
         mask    = ({`DCT_PRE_W{1'b1}} >> (2'd3 - sel));
         tick_of = ((pre & mask) == mask);
      end
   endfunction

   // Working register group substitution and bank swap
   assign eff_addr = (addr_i[7:4] == `DCT_WREG_GROUP) ?
                     {register_pointer[7:4], addr_i[3:0]} : addr_i;
   assign swap     = (eff_addr[7:4] == `DCT_SWAP_GROUP) &&
                     (register_pointer[3:0] != `DCT_BANK_NORMAL);
   assign hit_d    = swap && (register_pointer[3:0] == `DCT_BANK_D);
   assign hit_rp   = !swap && (eff_addr == `DCT_RP_ADDR);
   assign mem_wr   = wr_en_i && !swap && !hit_rp;
   assign mem_rd   = rd_en_i && !swap && !hit_rp;

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         register_pointer <= `DCT_RST_RP;
      end else if (wr_en_i && hit_rp) begin
         register_pointer <= wdata_i;
      end
   end

   // Free-running prescaler; first tick after a start may be short
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prescale <= {`DCT_PRE_W{1'b0}};
      end else begin
         prescale <= prescale + {{(`DCT_PRE_W-1){1'b0}}, 1'b1};
      end
   end

   assign byte_tick = tick_of(byte_clksel, prescale);
   assign word_tick = tick_of(word_clksel, prescale);

   // Start and stop requests
   assign raw_start_b = (wr_reg(`DCT_OFF_BYTE_CTL) && wdata_i[`DCT_B_ENABLE]) ||
                        (wr_reg(`DCT_OFF_COMB_CTL) && wdata_i[`DCT_B_BYTE_RUN]);
   assign raw_start_w = (wr_reg(`DCT_OFF_WORD_CTL) && wdata_i[`DCT_B_ENABLE]) ||
                        (wr_reg(`DCT_OFF_COMB_CTL) && wdata_i[`DCT_B_WORD_RUN]);
   assign start_b = raw_start_b || (sync_mode && raw_start_w);
   assign start_w = raw_start_w || (sync_mode && raw_start_b);
   assign stop_b  = wr_reg(`DCT_OFF_COMB_CTL) && !wdata_i[`DCT_B_BYTE_RUN] && !start_b;
   assign stop_w  = wr_reg(`DCT_OFF_COMB_CTL) && !wdata_i[`DCT_B_WORD_RUN] && !start_w;

   // Control register fields
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_single           <= 1'b0;
         byte_clksel           <= `DCT_RST_CLKSEL;
         byte_int_mask         <= 1'b0;
         byte_timer_pin_select <= 1'b0;
         byte_init             <= `DCT_RST_BYTE;
         word_single           <= 1'b0;
         word_clksel           <= `DCT_RST_CLKSEL;
         word_cap_mask         <= 1'b0;
         word_int_mask         <= 1'b0;
         word_timer_pin_select <= 1'b0;
         word_init             <= `DCT_RST_WORD;
         demod_en              <= 1'b0;
         edge_first            <= 1'b0;
         sync_mode             <= 1'b0;
      end else begin
         if (wr_reg(`DCT_OFF_BYTE_CTL)) begin
            byte_single           <= wdata_i[`DCT_B_SINGLE];
            byte_clksel           <= wdata_i[`DCT_B_CLK_HI:`DCT_B_CLK_LO];
            byte_int_mask         <= wdata_i[`DCT_B_INT_MASK];
            byte_timer_pin_select <= wdata_i[`DCT_B_PIN_SEL];
         end
         if (wr_reg(`DCT_OFF_WORD_CTL)) begin
            word_single           <= wdata_i[`DCT_B_SINGLE];
            word_clksel           <= wdata_i[`DCT_B_CLK_HI:`DCT_B_CLK_LO];
            word_cap_mask         <= wdata_i[`DCT_B_CAP_MASK];
            word_int_mask         <= wdata_i[`DCT_B_INT_MASK];
            word_timer_pin_select <= wdata_i[`DCT_B_PIN_SEL];
         end
         if (wr_reg(`DCT_OFF_DEMOD_CTL)) begin
            demod_en   <= wdata_i[`DCT_B_DEMOD_EN];
            edge_first <= wdata_i[`DCT_B_EDGE_FIRST];
         end
         if (wr_reg(`DCT_OFF_COMB_CTL)) begin
            sync_mode <= wdata_i[`DCT_B_SYNC];
         end
         if (wr_reg(`DCT_OFF_BYTE_INIT)) begin
            byte_init <= wdata_i;
         end
         if (wr_reg(`DCT_OFF_CAP_LOW)) begin
            word_init[7:0] <= wdata_i;
         end
         if (wr_reg(`DCT_OFF_CAP_HIGH)) begin
            word_init[15:8] <= wdata_i;
         end
      end
   end

   // Sticky flags: a set in the clearing cycle wins; writing 1 clears
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_timeout <= 1'b0;
         word_timeout <= 1'b0;
         cap_flag     <= 1'b0;
      end else begin
         byte_timeout <= byte_tc || (byte_timeout &&
                         !(wr_reg(`DCT_OFF_BYTE_CTL) && wdata_i[`DCT_B_TIMEOUT]));
         word_timeout <= word_tc || (word_timeout &&
                         !(wr_reg(`DCT_OFF_WORD_CTL) && wdata_i[`DCT_B_TIMEOUT]));
         cap_flag     <= demod_act || (cap_flag &&
                         !(wr_reg(`DCT_OFF_DEMOD_CTL) && wdata_i[`DCT_B_CAP_FLAG]));
      end
   end

   // Demodulation edge detection and capture
   assign demod_act = demod_en && word_running && (demod_q != demod_in_i) &&
                      (armed || !edge_first);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         demod_q      <= 1'b0;
         armed        <= 1'b0;
         capture_word <= `DCT_RST_WORD;
      end else begin
         demod_q <= demod_in_i;
         if (start_w) begin
            armed <= 1'b1;
         end else if (demod_act && edge_first) begin
            armed <= 1'b0;
         end
         if (demod_act) begin
            capture_word <= word_count;
         end
      end
   end

   // Timer outputs toggle at terminal count
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_out <= 1'b0;
         word_out <= 1'b0;
      end else begin
         if (byte_tc) begin
            byte_out <= !byte_out;
         end
         if (word_tc) begin
            word_out <= !word_out;
         end
      end
   end

   dct_counter #(.W(8)) u_byte (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_i),
      .start_i   (start_b),
      .stop_i    (stop_b),
      .tick_i    (byte_tick),
      .reload_i  (1'b0),
      .single_i  (byte_single),
      .init_i    (byte_init),
      .count_o   (byte_count),
      .running_o (byte_running),
      .tc_o      (byte_tc)
   );

   dct_counter #(.W(16)) u_word (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_i),
      .start_i   (start_w),
      .stop_i    (stop_w),
      .tick_i    (word_tick),
      .reload_i  (demod_act),
      .single_i  (word_single),
      .init_i    (word_init),
      .count_o   (word_count),
      .running_o (word_running),
      .tc_o      (word_tc)
   );

   dct_regfile #(.AW(AW), .DW(DW)) u_mem (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .addr_i  (eff_addr),
      .wr_en_i (mem_wr),
      .wdata_i (wdata_i),
      .rd_en_i (mem_rd),
      .rdata_o (mem_q)
   );

   // Pin steering and interrupt requests
   assign shared_pin_a_o = byte_timer_pin_select ? byte_out : port_a_data_i;
   assign shared_pin_b_o = word_timer_pin_select ? word_out : port_b_data_i;
   assign byte_irq_o     = byte_timeout && byte_int_mask;
   assign word_irq_o     = word_timeout && word_int_mask;
   assign capture_irq_o  = cap_flag && word_cap_mask;

   // Read path: stage 1 picks source, stage 2 drives rdata_o
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         periph_q   <= {DW{1'b0}};
         use_mem    <= 1'b0;
         rd_stage   <= 1'b0;
         rdata_o    <= {DW{1'b0}};
         rd_valid_o <= 1'b0;
      end else begin
         rd_stage   <= rd_en_i;
         use_mem    <= mem_rd;
         rd_valid_o <= rd_stage;
         periph_q   <= {DW{1'b0}};
         if (rd_en_i && hit_rp) begin
            periph_q <= register_pointer;
         end else if (rd_en_i && hit_d) begin
            case (eff_addr[3:0])
               `DCT_OFF_BYTE_CTL:  periph_q <= {byte_running, byte_single, byte_timeout,
                                    byte_clksel, 1'b0, byte_int_mask, byte_timer_pin_select};
               `DCT_OFF_DEMOD_CTL: periph_q <= {demod_en, edge_first, cap_flag, 5'h00};
               `DCT_OFF_WORD_CTL:  periph_q <= {word_running, word_single, word_timeout,
                                    word_clksel, word_cap_mask, word_int_mask,
                                    word_timer_pin_select};
               `DCT_OFF_COMB_CTL:  periph_q <= {word_running, byte_running, sync_mode,
                                    5'h00};
               `DCT_OFF_CAP_LOW:   periph_q <= capture_word[7:0];
               `DCT_OFF_CAP_HIGH:  periph_q <= capture_word[15:8];
               `DCT_OFF_BYTE_INIT: periph_q <= byte_init;
               default:            periph_q <= {DW{1'b0}};
            endcase
         end
         if (rd_stage) begin
            rdata_o <= use_mem ? mem_q : periph_q;
         end
      end
   end
endmodule
